// *** snp_pkg.sv ***
package snp_pkg;

   // Array geometry
   localparam int          ADDR_W        = 17;
   localparam int          DATA_W        = 8;
   localparam logic [16:0] QUARTER_BASE  = 17'h18000;
   localparam logic [16:0] HALF_BASE     = 17'h10000;
   localparam logic [16:0] ADDR_STEP     = 17'h00001;

   // Command opcodes
   localparam logic [7:0] OP_SET_WEN     = 8'h06;
   localparam logic [7:0] OP_CLR_WEN     = 8'h04;
   localparam logic [7:0] OP_STATUS_RD   = 8'h05;
   localparam logic [7:0] OP_STATUS_WR   = 8'h01;
   localparam logic [7:0] OP_ARRAY_RD    = 8'h03;
   localparam logic [7:0] OP_ARRAY_WR    = 8'h02;
   localparam logic [7:0] OP_CLOCK_WR    = 8'h12;
   localparam logic [7:0] OP_CLOCK_RD    = 8'h13;
   localparam logic [7:0] OP_SAVE        = 8'h3c;
   localparam logic [7:0] OP_RESTORE     = 8'h60;
   localparam logic [7:0] OP_AUTOSAVE_ON = 8'h59;
   localparam logic [7:0] OP_AUTOSAVE_OFF= 8'h19;

   // Status byte layout
   localparam int SR_BUSY   = 0;
   localparam int SR_WEN    = 1;
   localparam int SR_BG_LO  = 2;
   localparam int SR_BG_HI  = 3;
   localparam int SR_PGE    = 7;

   // Block guard codes
   localparam logic [1:0] GUARD_NONE    = 2'h0;
   localparam logic [1:0] GUARD_QUARTER = 2'h1;
   localparam logic [1:0] GUARD_HALF    = 2'h2;

   // Clock register file
   localparam int         RTC_REGS  = 16;
   localparam int         RTC_AW    = 4;
   localparam logic [3:0] RTC_FLAGS = 4'h0;
   localparam logic [3:0] RTC_STEP  = 4'h1;
   localparam int         FLAG_R    = 0;
   localparam int         FLAG_W    = 1;

   // Serial framing
   localparam logic [2:0] FIRST_BIT      = 3'h0;
   localparam logic [2:0] LAST_BIT       = 3'h7;
   localparam logic [2:0] BIT_STEP       = 3'h1;
   localparam logic [1:0] ADDR_BYTE_HI   = 2'h0;
   localparam logic [1:0] ADDR_BYTE_MID  = 2'h1;
   localparam logic [1:0] ADDR_BYTE_STEP = 2'h1;

   typedef enum logic [3:0] {
      ST_OPCODE, ST_ARR_ADDR, ST_ARR_RD, ST_ARR_WR, ST_SR_RD, ST_SR_DATA,
      ST_RTC_ADDR, ST_RTC_RD, ST_RTC_WR, ST_IGNORE
   } snp_link_st_t;

   typedef enum logic [3:0] {
      PEND_NONE, PEND_SET_WEN, PEND_CLR_WEN, PEND_WR_DONE, PEND_SR_WRITE,
      PEND_SAVE, PEND_RESTORE, PEND_AS_ON, PEND_AS_OFF
   } snp_pend_t;

endpackage

// *** snp_mem_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface snp_mem_if #(
   parameter int AW = snp_pkg::ADDR_W,
   parameter int DW = snp_pkg::DATA_W
);
   logic [AW-1:0] addr;
   logic [DW-1:0] wdata;
   logic          we;
   logic [DW-1:0] rdata;

   modport ctrl (output addr, output wdata, output we, input rdata);
   modport mem  (input addr, input wdata, input we, output rdata);
endinterface
`default_nettype wire

// *** snp_array.sv ***
`timescale 1ns/1ps
`default_nettype none
module snp_array #(
   parameter int AW = snp_pkg::ADDR_W,
   parameter int DW = snp_pkg::DATA_W
) (
   input wire logic clk_link,
   snp_mem_if.mem   port
);
   logic [DW-1:0] store_q [0:(1<<AW)-1];

   // Read is combinational so the first byte is ready at the falling edge
   // right after the last address bit.
   assign port.rdata = store_q[port.addr];

   always_ff @(posedge clk_link) begin
      if (port.we) begin
         store_q[port.addr] <= port.wdata;
      end
   end
endmodule
`default_nettype wire

// *** snp_access_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module snp_access_top (
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic sck,
   input  wire logic cs_n,
   input  wire logic si,
   input  wire logic wp_n,
   input  wire logic nv_busy,
   output logic      so,
   output logic      so_oe,
   output logic      write_enable,
   output logic      block_guard_low,
   output logic      block_guard_high,
   output logic      pin_guard_enable,
   output logic      save_req,
   output logic      restore_req,
   output logic      autosave_on_req,
   output logic      autosave_off_req,
   output logic      rtc_load,
   output logic      rtc_read_freeze
);
   localparam int AW = snp_pkg::ADDR_W;
   localparam int DW = snp_pkg::DATA_W;

   // ------------------------------------------------------------------
   // Link domain (serial clock); frame state is cleared while cs_n is high
   // ------------------------------------------------------------------
   snp_pkg::snp_link_st_t st_q;
   snp_pkg::snp_link_st_t st_d;
   snp_pkg::snp_pend_t    kind_d;
   snp_pkg::snp_pend_t    pend_kind_q;
   logic [6:0]            sh_q;
   logic [2:0]            bit_q;
   logic [1:0]            abyte_q;
   logic [AW-1:0]         addr_q;
   logic [3:0]            raddr_q;
   logic [DW-1:0]         pend_data_q;
   logic                  pend_tog_q;
   logic [DW-1:0]         rtc_q [snp_pkg::RTC_REGS];
   logic [DW-1:0]         sr_q;
   logic                  commit_tog_q;
   logic [DW-1:0]         srl_s1_q;
   logic [DW-1:0]         srl_s2_q;
   logic [6:0]            osh_q;
   logic                  so_q;
   logic                  so_oe_q;
   logic [DW-1:0]         byte_in;
   logic [DW-1:0]         rd_byte;
   logic                  byte_end;
   logic                  wen_l;
   logic [1:0]            bg_l;
   logic                  out_phase;
   logic                  arr_guarded;
   logic                  rtc_we;

   snp_mem_if #(.AW(AW), .DW(DW)) mem_bus ();

   snp_array #(.AW(AW), .DW(DW)) u_array (
      .clk_link (sck),
      .port     (mem_bus.mem)
   );

   assign byte_in  = {sh_q, si};
   assign byte_end = (bit_q == snp_pkg::LAST_BIT);
   assign wen_l    = srl_s2_q[snp_pkg::SR_WEN];
   assign bg_l     = {srl_s2_q[snp_pkg::SR_BG_HI], srl_s2_q[snp_pkg::SR_BG_LO]};
   assign out_phase = (st_q == snp_pkg::ST_ARR_RD) ||
                      (st_q == snp_pkg::ST_SR_RD)  ||
                      (st_q == snp_pkg::ST_RTC_RD);

   function automatic logic guarded(input logic [1:0]    bg,
                                    input logic [AW-1:0] a);
      logic g;
      g = 1'b1;
      unique case (bg)
         snp_pkg::GUARD_NONE:    g = 1'b0;
         snp_pkg::GUARD_QUARTER: g = (a >= snp_pkg::QUARTER_BASE);
         snp_pkg::GUARD_HALF:    g = (a >= snp_pkg::HALF_BASE);
         default:                g = 1'b1;
      endcase
      return g;
   endfunction

   assign arr_guarded = guarded(bg_l, addr_q);

   // Array port: writes only on the last bit of a data byte, and never into
   // a guarded region; the address still advances past it.
   assign mem_bus.addr  = addr_q;
   assign mem_bus.wdata = byte_in;
   assign mem_bus.we    = (st_q == snp_pkg::ST_ARR_WR) && byte_end &&
                          !arr_guarded;

   assign rtc_we = (st_q == snp_pkg::ST_RTC_WR) && byte_end &&
                   ((raddr_q == snp_pkg::RTC_FLAGS) ||
                    rtc_q[snp_pkg::RTC_FLAGS][snp_pkg::FLAG_W]);

   // Opcode decode; refused commands park in the ignore state until the
   // frame ends, so only a fresh chip-select fall restarts decoding.
   always_comb begin
      st_d   = st_q;
      kind_d = snp_pkg::PEND_NONE;
      unique case (st_q)
         snp_pkg::ST_OPCODE: begin
            st_d = snp_pkg::ST_IGNORE;
            case (byte_in)
               snp_pkg::OP_SET_WEN: kind_d = snp_pkg::PEND_SET_WEN;
               snp_pkg::OP_CLR_WEN: kind_d = snp_pkg::PEND_CLR_WEN;
               snp_pkg::OP_STATUS_RD: st_d = snp_pkg::ST_SR_RD;
               snp_pkg::OP_ARRAY_RD:  st_d = snp_pkg::ST_ARR_ADDR;
               snp_pkg::OP_CLOCK_RD:  st_d = snp_pkg::ST_RTC_ADDR;
               snp_pkg::OP_STATUS_WR: if (wen_l) begin
                  st_d   = snp_pkg::ST_SR_DATA;
                  kind_d = snp_pkg::PEND_WR_DONE;
               end
               snp_pkg::OP_ARRAY_WR: if (wen_l) begin
                  st_d   = snp_pkg::ST_ARR_ADDR;
                  kind_d = snp_pkg::PEND_WR_DONE;
               end
               snp_pkg::OP_CLOCK_WR: if (wen_l) begin
                  st_d   = snp_pkg::ST_RTC_ADDR;
                  kind_d = snp_pkg::PEND_WR_DONE;
               end
               snp_pkg::OP_SAVE:
                  if (wen_l) kind_d = snp_pkg::PEND_SAVE;
               snp_pkg::OP_RESTORE:
                  if (wen_l) kind_d = snp_pkg::PEND_RESTORE;
               snp_pkg::OP_AUTOSAVE_ON:
                  if (wen_l) kind_d = snp_pkg::PEND_AS_ON;
               snp_pkg::OP_AUTOSAVE_OFF:
                  if (wen_l) kind_d = snp_pkg::PEND_AS_OFF;
               default: st_d = snp_pkg::ST_IGNORE;
            endcase
         end
         snp_pkg::ST_ARR_ADDR: begin
            if (abyte_q ==
                snp_pkg::ADDR_BYTE_MID + snp_pkg::ADDR_BYTE_STEP) begin
               st_d = (pend_kind_q == snp_pkg::PEND_WR_DONE) ?
                      snp_pkg::ST_ARR_WR : snp_pkg::ST_ARR_RD;
            end else begin
               st_d = snp_pkg::ST_ARR_ADDR;
            end
         end
         snp_pkg::ST_RTC_ADDR: begin
            st_d = (pend_kind_q == snp_pkg::PEND_WR_DONE) ?
                   snp_pkg::ST_RTC_WR : snp_pkg::ST_RTC_RD;
         end
         snp_pkg::ST_SR_DATA: st_d = snp_pkg::ST_IGNORE;
         default: st_d = st_q;
      endcase
   end

   // Bit framing, msb first, sampled on rising edges in both modes.
   always_ff @(posedge sck or posedge rst or posedge cs_n) begin
      if (rst || cs_n) begin
         st_q  <= snp_pkg::ST_OPCODE;
         sh_q  <= '0;
         bit_q <= snp_pkg::FIRST_BIT;
      end else begin
         sh_q  <= byte_in[6:0];
         bit_q <= bit_q + snp_pkg::BIT_STEP;
         if (byte_end) begin
            st_q <= st_d;
         end
      end
   end

   // Address assembly and burst stepping for array and clock registers.
   always_ff @(posedge sck or posedge rst or posedge cs_n) begin
      if (rst || cs_n) begin
         abyte_q <= snp_pkg::ADDR_BYTE_HI;
         addr_q  <= '0;
         raddr_q <= snp_pkg::RTC_FLAGS;
      end else if (byte_end) begin
         unique case (st_q)
            snp_pkg::ST_ARR_ADDR: begin
               abyte_q <= abyte_q + snp_pkg::ADDR_BYTE_STEP;
               if (abyte_q == snp_pkg::ADDR_BYTE_HI) begin
                  addr_q[AW-1] <= byte_in[0];
               end else if (abyte_q == snp_pkg::ADDR_BYTE_MID) begin
                  addr_q[15:8] <= byte_in;
               end else begin
                  addr_q[7:0] <= byte_in;
               end
            end
            // Natural overflow of the 17-bit counter gives the wrap to zero
            snp_pkg::ST_ARR_RD: addr_q <= addr_q + snp_pkg::ADDR_STEP;
            snp_pkg::ST_ARR_WR: addr_q <= addr_q + snp_pkg::ADDR_STEP;
            snp_pkg::ST_RTC_ADDR:
               raddr_q <= byte_in[snp_pkg::RTC_AW-1:0];
            snp_pkg::ST_RTC_RD: raddr_q <= raddr_q + snp_pkg::RTC_STEP;
            snp_pkg::ST_RTC_WR: raddr_q <= raddr_q + snp_pkg::RTC_STEP;
            default: addr_q <= addr_q;
         endcase
      end
   end

   // Frame outcome kept across chip-select high so the system side can act
   // on the rising edge; the toggle marks a new, complete opcode.
   always_ff @(posedge sck or posedge rst) begin
      if (rst) begin
         pend_kind_q <= snp_pkg::PEND_NONE;
         pend_data_q <= '0;
         pend_tog_q  <= 1'b0;
      end else if (!cs_n && byte_end && st_q == snp_pkg::ST_OPCODE) begin
         pend_kind_q <= kind_d;
         pend_tog_q  <= ~pend_tog_q;
      end else if (!cs_n && byte_end && st_q == snp_pkg::ST_SR_DATA) begin
         pend_kind_q <= snp_pkg::PEND_SR_WRITE;
         pend_data_q <= byte_in;
      end
   end

   // Clock register file, one process per entry.
   for (genvar i = 0; i < snp_pkg::RTC_REGS; i++) begin : g_rtc
      always_ff @(posedge sck or posedge rst) begin
         if (rst) begin
            rtc_q[i] <= '0;
         end else if (!cs_n && rtc_we &&
                      raddr_q == snp_pkg::RTC_AW'(i)) begin
            rtc_q[i] <= byte_in;
         end
      end
   end

   // Clearing the write-hold flag hands the staged values to the counters.
   always_ff @(posedge sck or posedge rst) begin
      if (rst) begin
         commit_tog_q <= 1'b0;
      end else if (!cs_n && rtc_we && raddr_q == snp_pkg::RTC_FLAGS &&
                   rtc_q[snp_pkg::RTC_FLAGS][snp_pkg::FLAG_W] &&
                   !byte_in[snp_pkg::FLAG_W]) begin
         commit_tog_q <= ~commit_tog_q;
      end
   end

   // Status byte is quasi-static during a frame: apart from the busy bit, which
   // follows nv_busy, it only changes at a frame end, so a plain two-stage sync
   // is enough on this side.
   always_ff @(posedge sck or posedge rst) begin
      if (rst) begin
         srl_s1_q <= '0;
         srl_s2_q <= '0;
      end else begin
         srl_s1_q <= sr_q;
         srl_s2_q <= srl_s1_q;
      end
   end

   always_comb begin
      unique case (st_q)
         snp_pkg::ST_SR_RD:  rd_byte = srl_s2_q;
         snp_pkg::ST_RTC_RD: rd_byte = rtc_q[raddr_q];
         default:            rd_byte = mem_bus.rdata;
      endcase
   end

   // Output shifter on falling edges; serial in plays no part here.
   always_ff @(negedge sck or posedge rst or posedge cs_n) begin
      if (rst || cs_n) begin
         so_q    <= 1'b0;
         so_oe_q <= 1'b0;
         osh_q   <= '0;
      end else if (out_phase) begin
         so_oe_q <= 1'b1;
         if (bit_q == snp_pkg::FIRST_BIT) begin
            {so_q, osh_q} <= rd_byte;
         end else begin
            {so_q, osh_q} <= {osh_q, 1'b0};
         end
      end else begin
         so_oe_q <= 1'b0;
      end
   end

   assign so    = so_q;
   assign so_oe = so_oe_q;

   // ------------------------------------------------------------------
   // System domain
   // ------------------------------------------------------------------
   logic          cs_s1_q;
   logic          cs_s2_q;
   logic          cs_s3_q;
   logic          wp_s1_q;
   logic          wp_s2_q;
   logic          busy_s1_q;
   logic          busy_s2_q;
   logic          ct_s1_q;
   logic          ct_s2_q;
   logic          ct_s3_q;
   logic          fr_s1_q;
   logic          fr_s2_q;
   logic          seen_q;
   logic          lock_q;
   logic          wen_q;
   logic [1:0]    bg_q;
   logic          pge_q;
   logic          frame_end;
   logic          cs_fall;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cs_s1_q   <= 1'b1;
         cs_s2_q   <= 1'b1;
         cs_s3_q   <= 1'b1;
         wp_s1_q   <= 1'b1;
         wp_s2_q   <= 1'b1;
         busy_s1_q <= 1'b0;
         busy_s2_q <= 1'b0;
         ct_s1_q   <= 1'b0;
         ct_s2_q   <= 1'b0;
         ct_s3_q   <= 1'b0;
         fr_s1_q   <= 1'b0;
         fr_s2_q   <= 1'b0;
      end else begin
         cs_s1_q   <= cs_n;
         cs_s2_q   <= cs_s1_q;
         cs_s3_q   <= cs_s2_q;
         wp_s1_q   <= wp_n;
         wp_s2_q   <= wp_s1_q;
         busy_s1_q <= nv_busy;
         busy_s2_q <= busy_s1_q;
         ct_s1_q   <= commit_tog_q;
         ct_s2_q   <= ct_s1_q;
         ct_s3_q   <= ct_s2_q;
         fr_s1_q   <= rtc_q[snp_pkg::RTC_FLAGS][snp_pkg::FLAG_R];
         fr_s2_q   <= fr_s1_q;
      end
   end

   // Link state is frozen while cs_n is high, so the outcome is stable
   // when the synchronised rising edge arrives.
   assign cs_fall   = cs_s3_q && !cs_s2_q;
   assign frame_end = cs_s2_q && !cs_s3_q && (pend_tog_q != seen_q);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         seen_q <= 1'b0;
         lock_q <= 1'b0;
      end else begin
         if (frame_end) begin
            seen_q <= pend_tog_q;
         end
         if (cs_fall) begin
            lock_q <= pge_q && !wp_s2_q;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wen_q <= 1'b0;
      end else if (frame_end) begin
         unique case (pend_kind_q)
            snp_pkg::PEND_NONE:    wen_q <= wen_q;
            snp_pkg::PEND_SET_WEN: wen_q <= 1'b1;
            snp_pkg::PEND_CLR_WEN: wen_q <= 1'b0;
            default:               wen_q <= 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         bg_q  <= snp_pkg::GUARD_NONE;
         pge_q <= 1'b0;
      end else if (frame_end && !lock_q &&
                   pend_kind_q == snp_pkg::PEND_SR_WRITE) begin
         bg_q  <= {pend_data_q[snp_pkg::SR_BG_HI],
                   pend_data_q[snp_pkg::SR_BG_LO]};
         pge_q <= pend_data_q[snp_pkg::SR_PGE];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sr_q <= '0;
      end else begin
         sr_q <= '0;
         sr_q[snp_pkg::SR_BUSY]  <= busy_s2_q;
         sr_q[snp_pkg::SR_WEN]   <= wen_q;
         sr_q[snp_pkg::SR_BG_LO] <= bg_q[0];
         sr_q[snp_pkg::SR_BG_HI] <= bg_q[1];
         sr_q[snp_pkg::SR_PGE]   <= pge_q;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         save_req         <= 1'b0;
         restore_req      <= 1'b0;
         autosave_on_req  <= 1'b0;
         autosave_off_req <= 1'b0;
         rtc_load         <= 1'b0;
      end else begin
         save_req         <= frame_end && pend_kind_q == snp_pkg::PEND_SAVE;
         restore_req      <= frame_end && pend_kind_q == snp_pkg::PEND_RESTORE;
         autosave_on_req  <= frame_end && pend_kind_q == snp_pkg::PEND_AS_ON;
         autosave_off_req <= frame_end && pend_kind_q == snp_pkg::PEND_AS_OFF;
         rtc_load         <= ct_s2_q != ct_s3_q;
      end
   end

   assign write_enable     = wen_q;
   assign block_guard_low  = bg_q[0];
   assign block_guard_high = bg_q[1];
   assign pin_guard_enable = pge_q;
   assign rtc_read_freeze  = fr_s2_q;
endmodule
`default_nettype wire

// *** snp_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module snp_host_model (
   output logic      sck,
   output logic      cs_n,
   output logic      si,
   input  wire logic clk_sys,
   input  wire logic so
);
   logic [7:0] tx[$];
   logic [7:0] rx;
   int         ncap;
   event       got;
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
   end
   // Mode 0 at 80 ns; clock stands still between frames
   task automatic send();
      @(posedge clk_sys);
      #7 cs_n = 1'b0;
      foreach (tx[k]) begin
         for (int i = 7; i >= 0; i--) begin
            si = tx[k][i];
            #40 sck = 1'b1;
            rx[i] = so;
            #40 sck = 1'b0;
         end
         if (k >= tx.size() - ncap) ->got;
      end
      #40 cs_n = 1'b1;
      si = ~si;
      tx.delete();
      // Gap lets effects land before the next opcode
      #1000;
   endtask
endmodule
`default_nettype wire

// *** snp_access_top_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module snp_access_top_monitor (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic so_oe,
   input wire logic write_enable,
   input wire logic block_guard_low,
   input wire logic block_guard_high,
   input wire logic pin_guard_enable,
   input wire logic save_req,
   input wire logic restore_req,
   input wire logic autosave_on_req,
   input wire logic autosave_off_req,
   input wire logic rtc_load
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic [3:0] nv;
   logic [2:0] grd;
   assign nv = {save_req, restore_req, autosave_on_req, autosave_off_req};
   assign grd = {pin_guard_enable, block_guard_high, block_guard_low};
   property p_rst_clr;
      $fell(rst) |-> !write_enable;
   endproperty
   a_rst_clr: assert property (p_rst_clr)
      else $error("latch set after reset");
   property p_wen_rise;
      $rose(write_enable) |-> cs_n;
   endproperty
   a_wen_rise: assert property (p_wen_rise)
      else $error("latch set inside a frame");
   property p_wen_fall;
      $fell(write_enable) |-> cs_n;
   endproperty
   a_wen_fall: assert property (p_wen_fall)
      else $error("latch cleared inside a frame");
   property p_nv_clr;
      (|nv) |-> ##[0:4] !write_enable;
   endproperty
   a_nv_clr: assert property (p_nv_clr)
      else $error("latch kept after special command");
   property p_one_pulse;
      $onehot0({nv, rtc_load});
   endproperty
   a_one_pulse: assert property (p_one_pulse)
      else $error("two request pulses at once");
   property p_grd_idle;
      $changed(grd) |-> cs_n;
   endproperty
   a_grd_idle: assert property (p_grd_idle)
      else $error("guard bits moved inside a frame");
   property p_grd_wen;
      $changed(grd) |-> $past(write_enable) || $past(write_enable, 2);
   endproperty
   a_grd_wen: assert property (p_grd_wen)
      else $error("guard bits moved without latch");
   property p_so_idle;
      cs_n && $past(cs_n) |-> !so_oe;
   endproperty
   a_so_idle: assert property (p_so_idle)
      else $error("serial out driven while deselected");
endmodule
bind snp_access_top snp_access_top_monitor u_mon (.clk_sys, .rst, .cs_n,
   .so_oe, .write_enable, .block_guard_low, .block_guard_high,
   .pin_guard_enable, .save_req, .restore_req, .autosave_on_req,
   .autosave_off_req, .rtc_load);
`default_nettype wire

// *** snp_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        clk_sys, rst, wp_n, nv_busy, so, so_oe, write_enable;
   logic        block_guard_low, block_guard_high, pin_guard_enable;
   logic        save_req, restore_req, autosave_on_req, autosave_off_req;
   logic        rtc_load, rtc_read_freeze;
   wire logic   sck, cs_n, si;
   logic [31:0] seed = 32'h4d14;
   logic [7:0]  exp_q[$];
   logic [7:0]  a, b, c;
   int          errors = 0, cmp_count = 0, npulse = 0;
   logic [7:0]  nvc[4] = '{snp_pkg::OP_SAVE, snp_pkg::OP_RESTORE,
                           snp_pkg::OP_AUTOSAVE_ON, snp_pkg::OP_AUTOSAVE_OFF};
   snp_access_top uut (.clk_sys, .rst, .sck, .cs_n, .si, .wp_n, .nv_busy,
      .so, .so_oe, .write_enable, .block_guard_low, .block_guard_high,
      .pin_guard_enable, .save_req, .restore_req, .autosave_on_req,
      .autosave_off_req, .rtc_load, .rtc_read_freeze);
   snp_host_model host (.sck, .cs_n, .si, .clk_sys, .so);
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic chk_bit(input logic e, input logic g);
      chk_byte({7'h00, e}, {7'h00, g});
   endtask
   task automatic go(input int n);
      host.ncap = n;
      host.send();
   endtask
   task automatic wen();
      host.tx = '{snp_pkg::OP_SET_WEN};
      go(0);
   endtask
   task automatic arr(input logic [7:0] o, input logic [16:0] ad,
                      input logic [7:0] d0, input logic [7:0] d1, input int n);
      host.tx = '{o, {7'h00, ad[16]}, ad[15:8], ad[7:0], d0, d1};
      go(n);
   endtask
   task automatic rd(input logic [16:0] ad, input logic [7:0] e0,
                     input logic [7:0] e1);
      exp_q.push_back(e0);
      exp_q.push_back(e1);
      arr(snp_pkg::OP_ARRAY_RD, ad, rnd(), rnd(), 2);
   endtask
   task automatic complete_run();
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(host.got) chk_byte(exp_q.pop_front(), host.rx);
   always @(posedge clk_sys)
      if (save_req | restore_req | autosave_on_req | autosave_off_req
          | rtc_load) npulse <= npulse + 1;
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   initial begin
      #1000000;
      errors++;
      $display("unexpected at %0t: run hung", $time);
      complete_run();
   end
   initial begin
      rst = 1'b1;
      wp_n = 1'b1;
      nv_busy = 1'b0;
      repeat (12) @(posedge clk_sys);
      #7 rst = 1'b0;
      repeat (3) @(posedge clk_sys);
      chk_bit(1'b0, write_enable);
      a = rnd();
      b = rnd();
      c = rnd();
      wen();
      chk_bit(1'b1, write_enable);
      arr(snp_pkg::OP_ARRAY_WR, 17'h1ffff, a, b, 0);
      chk_bit(1'b0, write_enable);
      arr(snp_pkg::OP_ARRAY_WR, 17'h1ffff, c, c, 0);
      rd(17'h1ffff, a, b);
      wen();
      host.tx = '{snp_pkg::OP_CLR_WEN};
      go(0);
      chk_bit(1'b0, write_enable);
      wen();
      arr(snp_pkg::OP_ARRAY_WR, 17'h17fff, a, b, 0);
      wen();
      host.tx = '{snp_pkg::OP_STATUS_WR, 8'hf4};
      go(0);
      chk_bit(1'b1, block_guard_low);
      nv_busy = 1'b1;
      exp_q.push_back(8'h85);
      host.tx = '{snp_pkg::OP_STATUS_RD, rnd()};
      go(1);
      nv_busy = 1'b0;
      wen();
      arr(snp_pkg::OP_ARRAY_WR, 17'h17fff, c, c, 0);
      rd(17'h17fff, c, b);
      @(posedge clk_sys);
      #7 wp_n = 1'b0;
      wen();
      host.tx = '{snp_pkg::OP_STATUS_WR, 8'h00};
      go(0);
      chk_bit(1'b1, pin_guard_enable);
      @(posedge clk_sys);
      #7 wp_n = 1'b1;
      wen();
      fork
         go(0);
         begin
            repeat (4) @(posedge clk_sys);
            #7 wp_n = 1'b0;
         end
         host.tx = '{snp_pkg::OP_STATUS_WR, 8'h00};
      join
      chk_bit(1'b0, pin_guard_enable);
      wen();
      host.tx = '{snp_pkg::OP_STATUS_WR, 8'h08};
      go(0);
      chk_bit(1'b1, block_guard_high);
      foreach (nvc[i]) begin
         wen();
         host.tx = '{nvc[i]};
         go(0);
      end
      host.tx = '{snp_pkg::OP_SAVE};
      go(0);
      wen();
      host.tx = '{snp_pkg::OP_CLOCK_WR, 8'h00, 8'h01};
      go(0);
      chk_bit(1'b1, rtc_read_freeze);
      exp_q.push_back(8'h01);
      host.tx = '{snp_pkg::OP_CLOCK_RD, 8'h00, rnd()};
      go(1);
      wen();
      host.tx = '{snp_pkg::OP_CLOCK_WR, 8'h00, 8'h02};
      go(0);
      wen();
      host.tx = '{snp_pkg::OP_CLOCK_WR, 8'h00, 8'h00};
      go(0);
      chk_bit(1'b1, npulse == 5);
      complete_run();
   end
endmodule
`default_nettype wire
